// file: rtl/tsb_pkg.sv
// Shared constants for the two-wire addressed serial bus: register map,
// field positions, byte kinds and link timing.
// Assumes a 250 MHz system clock on both ends.
`default_nettype none
package tsb_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned SCK_PERIOD_NS = 32;
  // System clocks per half period of the generated serial clock.
  localparam int unsigned SCK_HALF_CLKS = (SCK_PERIOD_NS * CLK_MHZ) / 2000;
  localparam logic [7:0]  SCK_HALF_LAST = 8'(SCK_HALF_CLKS - 1);
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  // Clock pulses after a byte in which an acknowledge must show.
  localparam logic [2:0]  ACK_WAIT_CLKS = 3'h3;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL  = 4'h0;
  localparam logic [3:0] ADR_STAT  = 4'h4;
  localparam logic [3:0] ADR_SHIFT = 4'h8;
  localparam logic [3:0] ADR_SADDR = 4'hc;

  // Control register fields.
  localparam int CTL_EN   = 0;
  localparam int CTL_WUP  = 1;
  localparam int CTL_ACKE = 2;
  localparam int CTL_BSYE = 3;
  localparam int CTL_ACKT = 4;

  // Status register fields.
  localparam int ST_TIF   = 0;
  localparam int ST_RELEASE_DETECTED_FLAG  = 1;
  localparam int ST_COMMAND_DETECTED_FLAG  = 2;
  localparam int ST_ACKD  = 3;
  localparam int ST_NACK  = 4;
  localparam int ST_SEL   = 5;
  localparam int ST_KIND  = 6;
  localparam int ST_MATCH = 8;
  localparam int ST_BUSY  = 9;

  localparam logic [7:0] SADDR_RESET = 8'h00;

  typedef enum logic [1:0] {
    TSB_KIND_DATA,
    TSB_KIND_CMD,
    TSB_KIND_ADDR
  } tsb_kind_t;

endpackage : tsb_pkg
`default_nettype wire

// file: rtl/tsb_if.sv
// Two-wire serial bus carrier: one clock line and one open-drain data line.
// Assumes a pull-up on the data line; the line is low while any end
// enables a low drive.
`timescale 1ns/10ps
`default_nettype none
interface tsb_if;
  logic sck;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic sda;

  // Wired-OR of the open-drain drivers against the pull-up.
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (mst_sda_oe & ~mst_sda_o));

  modport dev (input sck, input sda, output dev_sda_o, output dev_sda_oe);
  modport mst (output sck, input sda, output mst_sda_o, output mst_sda_oe);
endinterface : tsb_if
`default_nettype wire

// file: rtl/tsb_dev.sv
// Device end of the two-wire serial bus: slave channel with register
// access over classic Wishbone.
// Assumes one master on the bus makes every clock pulse and every
// release and command condition.
//
// Summary of operation
// - Shift register write starts transfer when allowed
// - Enable set after the write starts nothing
// - Stop after eight bits, set transfer flag
// - Hardware classifies byte as address, command, data
// - Data pin is open-drain, wired-OR
// - Wake-up: interrupt only on matching address
// - Data rising while clock rests high: release
// - Data falling while clock rests high: command
// - Only master makes release and command
// - Address after release compared; selection held
// - Command after release announces an address
// - Command-led byte is command, else data
// - Acknowledge is one-clock pulse from falling edge
// - Receiver of the byte returns acknowledge
// - Transmitter flags missing acknowledge after preset time
// - Busy drives data low, changes at falling edges
// - Master clocks until busy removed, then stops
// - Master waits for ready before next transfer
// - Busy lasts to next fall; wake-up holds it
// - Exactly one master sources clock and conditions
// - Wake-up match needs release and command seen
// - Shift out on each falling clock edge
// - Release sets release flag, clears command flag
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module tsb_dev (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Channel events
  output logic             chan_irq_o,
  // Serial bus
  tsb_if.dev               bus
);
  import tsb_pkg::*;

  typedef enum {S_IDLE, S_SHIFT, S_POST} tsb_dev_st_t;

  tsb_dev_st_t st_reg;
  logic [1:0]  sck_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic        sck_d_reg;
  logic        sda_d_reg;
  logic        ack_reg;
  logic        en_reg;
  logic        wup_reg;
  logic        acke_reg;
  logic        bsye_reg;
  logic        ackt_reg;
  logic [7:0]  saddr_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  cnt_reg;
  logic        out_reg;
  logic        rel_reg;
  logic        cmd_reg;
  logic        sel_reg;
  logic        match_reg;
  tsb_kind_t   kind_reg;
  logic        tif_reg;
  logic        ackd_reg;
  logic        nack_reg;
  logic        ack_drv_reg;
  logic        ack_done_reg;
  logic        busy_reg;
  logic [2:0]  post_cnt_reg;
  logic        irq_reg;

  logic        sck_s;
  logic        sda_s;
  logic        rise;
  logic        fall;
  logic        rel_det;
  logic        cmd_det;
  logic        wr;
  logic        start;
  logic        done;
  logic [7:0]  nxt_byte;
  logic        nxt_match;
  tsb_kind_t   nxt_kind;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sck_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], bus.sck};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      sck_d_reg    <= sck_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  assign sck_s   = sck_sync_reg[1];
  assign sda_s   = sda_sync_reg[1];
  assign rise    = sck_s & ~sck_d_reg;
  assign fall    = ~sck_s & sck_d_reg;
  // Both clock samples high means the clock rests, so a data edge here
  // is a bus condition rather than a data bit.
  assign rel_det = en_reg & sck_s & sck_d_reg & sda_s & ~sda_d_reg;
  assign cmd_det = en_reg & sck_s & sck_d_reg & ~sda_s & sda_d_reg;

  // ---------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, writes land on
  // the edge that samples ack.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
      case (wb_adr_i)
        ADR_CTRL:  wb_dat_o <= {27'h0, ackt_reg, bsye_reg, acke_reg, wup_reg, en_reg};
        ADR_STAT:  wb_dat_o <= {22'h0, busy_reg, match_reg, kind_reg, sel_reg, nack_reg,
                               ackd_reg, cmd_reg, rel_reg, tif_reg};
        ADR_SHIFT: wb_dat_o <= {24'h0, sh_reg};
        ADR_SADDR: wb_dat_o <= {24'h0, saddr_reg};
        default:   wb_dat_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg    <= 1'b0;
      wup_reg   <= 1'b0;
      acke_reg  <= 1'b0;
      bsye_reg  <= 1'b0;
      saddr_reg <= SADDR_RESET;
    end else if (wr && wb_adr_i == ADR_CTRL) begin
      en_reg    <= wb_dat_i[CTL_EN];
      wup_reg   <= wb_dat_i[CTL_WUP];
      acke_reg  <= wb_dat_i[CTL_ACKE];
      bsye_reg  <= wb_dat_i[CTL_BSYE];
    end else if (wr && wb_adr_i == ADR_SADDR) begin
      saddr_reg <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Shift sequencing
  // ---------------------------------------------------------------
  // Enable is sampled as it stands at the write, so a write before the
  // enable starts nothing.
  assign start = wr && wb_adr_i == ADR_SHIFT && en_reg
                 && st_reg != S_SHIFT && sck_s;
  assign done      = st_reg == S_SHIFT && rise && cnt_reg == LAST_BIT;
  assign nxt_byte  = {sh_reg[6:0], sda_s};
  assign nxt_match = nxt_byte == saddr_reg;

  always_comb begin
    if (rel_reg && cmd_reg) begin
      nxt_kind = TSB_KIND_ADDR;
    end else if (cmd_reg) begin
      nxt_kind = TSB_KIND_CMD;
    end else begin
      nxt_kind = TSB_KIND_DATA;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      st_reg  <= S_IDLE;
      cnt_reg <= 4'h0;
    end else if (start) begin
      st_reg  <= S_SHIFT;
      cnt_reg <= 4'h0;
    end else begin
      case (st_reg)
        S_SHIFT: begin
          if (rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (done) begin
            st_reg <= S_POST;
          end
        end
        S_IDLE:  st_reg <= S_IDLE;
        S_POST:  st_reg <= S_POST;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 8'h0;
    end else if (start) begin
      sh_reg <= wb_dat_i[7:0];
    end else if (st_reg == S_SHIFT && rise) begin
      sh_reg <= nxt_byte;
    end
  end

  // The last bit is held until the falling edge so the line never rises
  // while the clock is high, which would read as a bus release.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      out_reg <= 1'b1;
    end else if (start) begin
      out_reg <= wb_dat_i[7];
    end else if (fall) begin
      out_reg <= (st_reg == S_SHIFT) ? sh_reg[7] : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bus conditions, classification and selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      rel_reg   <= 1'b0;
      cmd_reg   <= 1'b0;
      sel_reg   <= 1'b0;
      match_reg <= 1'b0;
      kind_reg  <= TSB_KIND_DATA;
    end else if (rel_det) begin
      rel_reg <= 1'b1;
      cmd_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else if (cmd_det) begin
      cmd_reg <= 1'b1;
    end else if (done) begin
      rel_reg  <= 1'b0;
      cmd_reg  <= 1'b0;
      kind_reg <= nxt_kind;
      if (nxt_kind == TSB_KIND_ADDR) begin
        match_reg <= nxt_match;
        sel_reg   <= nxt_match;
      end
    end
  end

  // Transfer flag: set wins over the write-one clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tif_reg <= 1'b0;
    end else if (done) begin
      tif_reg <= 1'b1;
    end else if (wr && wb_adr_i == ADR_STAT && wb_dat_i[ST_TIF]) begin
      tif_reg <= 1'b0;
    end
  end

  // With wake-up on, only an address that follows release and command
  // and equals the own address interrupts; other bytes stay silent.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done && (!wup_reg || (nxt_kind == TSB_KIND_ADDR && nxt_match));
    end
  end

  assign chan_irq_o = irq_reg;

  // ---------------------------------------------------------------
  // Acknowledge, busy and acknowledge check
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg || start) begin
      ackt_reg <= 1'b0;
    end else if (wr && wb_adr_i == ADR_CTRL && wb_dat_i[CTL_ACKT]) begin
      ackt_reg <= 1'b1;
    end else if (ack_drv_reg) begin
      ackt_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg || start) begin
      ack_drv_reg  <= 1'b0;
      ack_done_reg <= 1'b0;
    end else if (st_reg == S_POST && fall) begin
      if (ack_drv_reg) begin
        ack_drv_reg  <= 1'b0;
        ack_done_reg <= 1'b1;
      end else if ((acke_reg || ackt_reg) && !ack_done_reg) begin
        ack_drv_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg || start) begin
      busy_reg <= 1'b0;
    end else if (st_reg == S_POST && fall) begin
      if (ack_drv_reg && bsye_reg) begin
        busy_reg <= 1'b1;
      end else if (!bsye_reg && !wup_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // A low line on a rising edge after the byte, not of our own making,
  // is the far end's acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg || start) begin
      ackd_reg     <= 1'b0;
      nack_reg     <= 1'b0;
      post_cnt_reg <= 3'h0;
    end else if (st_reg == S_POST && rise && !ack_drv_reg && !busy_reg) begin
      if (!sda_s) begin
        ackd_reg <= 1'b1;
      end else if (!ackd_reg) begin
        post_cnt_reg <= post_cnt_reg + 3'h1;
        if (post_cnt_reg == ACK_WAIT_CLKS - 3'h1) begin
          nack_reg <= 1'b1;
        end
      end
    end
  end

  // Open-drain: only ever pulls low.
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = ~out_reg | ack_drv_reg | busy_reg;

endmodule : tsb_dev
`default_nettype wire

// file: rtl/tsb_mst.sv
// Master end of the two-wire serial bus: makes the serial clock by
// dividing its own clock, issues release and command conditions and
// bytes, and keeps clocking until the slave shows ready.
// Assumes it is the only master on the bus.
`timescale 1ns/10ps
`default_nettype none
module tsb_mst (
  // System
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Request
  input  wire logic                req_valid_i,
  output logic                     req_ready_o,
  input  wire tsb_pkg::tsb_kind_t  req_kind_i,
  input  wire logic [7:0]          req_data_i,
  input  wire logic                req_ack_i,
  // Answer
  output logic                     done_o,
  output logic [7:0]               rx_data_o,
  output logic                     ack_seen_o,
  output logic                     nack_o,
  // Serial bus
  tsb_if.mst                       bus
);
  import tsb_pkg::*;

  typedef enum {M_IDLE, M_REL, M_CMD, M_GAP, M_LOW, M_HIGH} tsb_mst_st_t;

  tsb_mst_st_t st_reg;
  logic [1:0]  sda_sync_reg;
  logic [7:0]  tmr_reg;
  logic        sck_reg;
  logic        low_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  bit_reg;
  logic [2:0]  post_reg;
  logic        mack_reg;
  logic        done_reg;
  logic [7:0]  rx_reg;
  logic        ack_reg;
  logic        nack_reg;
  logic        tick;
  logic        sda_s;

  // ---------------------------------------------------------------
  // Line input and half-period timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  assign sda_s = sda_sync_reg[1];
  assign tick  = tmr_reg == SCK_HALF_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i || st_reg == M_IDLE || tick) begin
      tmr_reg <= 8'h0;
    end else begin
      tmr_reg <= tmr_reg + 8'h1;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Busy or acknowledge low on the line keeps the clock running; a high
  // line after an acknowledge stops it with the clock resting high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg   <= M_IDLE;
      sck_reg  <= 1'b1;
      low_reg  <= 1'b0;
      sh_reg   <= 8'h0;
      bit_reg  <= 4'h0;
      post_reg <= 3'h0;
      mack_reg <= 1'b0;
      done_reg <= 1'b0;
      rx_reg   <= 8'h0;
      ack_reg  <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (st_reg)
        M_IDLE: begin
          if (req_valid_i) begin
            sh_reg   <= req_data_i;
            mack_reg <= req_ack_i;
            bit_reg  <= 4'h0;
            post_reg <= 3'h0;
            ack_reg  <= 1'b0;
            nack_reg <= 1'b0;
            if (req_kind_i == TSB_KIND_ADDR) begin
              low_reg <= 1'b1;
              st_reg  <= M_REL;
            end else if (req_kind_i == TSB_KIND_CMD) begin
              st_reg <= M_CMD;
            end else begin
              sck_reg <= 1'b0;
              low_reg <= ~req_data_i[7];
              st_reg  <= M_LOW;
            end
          end
        end
        M_REL: if (tick) begin
          low_reg <= 1'b0;
          st_reg  <= M_CMD;
        end
        M_CMD: if (tick) begin
          low_reg <= 1'b1;
          st_reg  <= M_GAP;
        end
        M_GAP: if (tick) begin
          sck_reg <= 1'b0;
          low_reg <= ~sh_reg[7];
          st_reg  <= M_LOW;
        end
        M_LOW: if (tick) begin
          sck_reg <= 1'b1;
          st_reg  <= M_HIGH;
        end
        M_HIGH: if (tick) begin
          if (bit_reg < BYTE_BITS) begin
            rx_reg  <= {rx_reg[6:0], sda_s};
            sh_reg  <= {sh_reg[6:0], 1'b1};
            bit_reg <= bit_reg + 4'h1;
            sck_reg <= 1'b0;
            st_reg  <= M_LOW;
            // After the last bit the master acknowledges a byte it
            // received, or releases the line.
            low_reg <= (bit_reg == LAST_BIT) ? mack_reg : ~sh_reg[6];
          end else if (!sda_s) begin
            ack_reg <= 1'b1;
            low_reg <= 1'b0;
            sck_reg <= 1'b0;
            st_reg  <= M_LOW;
          end else if (ack_reg) begin
            done_reg <= 1'b1;
            st_reg   <= M_IDLE;
          end else if (post_reg == ACK_WAIT_CLKS - 3'h1) begin
            nack_reg <= 1'b1;
            done_reg <= 1'b1;
            st_reg   <= M_IDLE;
          end else begin
            post_reg <= post_reg + 3'h1;
            sck_reg  <= 1'b0;
            st_reg   <= M_LOW;
          end
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end

  assign req_ready_o    = st_reg == M_IDLE;
  assign done_o         = done_reg;
  assign rx_data_o      = rx_reg;
  assign ack_seen_o     = ack_reg;
  assign nack_o         = nack_reg;
  assign bus.sck        = sck_reg;
  assign bus.mst_sda_o  = 1'b0;
  assign bus.mst_sda_oe = low_reg;

endmodule : tsb_mst
`default_nettype wire

// file: verification/tsb_chk.sv
// Checker on the serial bus carrier: line levels and serial clock timing.
// Assumes both ends run on the one system clock clk_i.
`timescale 1ns/10ps
`default_nettype none
module tsb_chk (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus lines
  input wire logic sck,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic mst_sda_o,
  input wire logic mst_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_dev_od; dev_sda_oe |-> !dev_sda_o; endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives data high");
  property p_mst_od; mst_sda_oe |-> !mst_sda_o; endproperty
  a_mst_od: assert property (p_mst_od) else $error("master drives data high");
  property p_pull; !dev_sda_oe && !mst_sda_oe |-> sda; endproperty
  a_pull: assert property (p_pull) else $error("released line not high");
  property p_wor; dev_sda_oe || mst_sda_oe |-> !sda; endproperty
  a_wor: assert property (p_wor) else $error("driven line not low");
  // Reset must leave the clock resting high and both ends off the line.
  property p_rst; @(posedge clk_i) disable iff (1'b0) rst_i |=> sck && !dev_sda_oe && !mst_sda_oe; endproperty
  a_rst: assert property (p_rst) else $error("bus not idle after reset");
  property p_low; $fell(sck) |-> !sck [*4] ##1 sck; endproperty
  a_low: assert property (p_low) else $error("clock low phase wrong");
  property p_high; $rose(sck) |-> sck [*4]; endproperty
  a_high: assert property (p_high) else $error("clock high phase short");
  // A device edge while the clock is high would look like a condition.
  property p_dev_edge; $changed(dev_sda_oe) |-> !sck; endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device edge with clock high");
  c_rel: cover property (sck && $rose(sda));
  c_cmd: cover property (sck && $fell(sda));
  c_ack: cover property ($rose(dev_sda_oe));
  c_busy: cover property (dev_sda_oe [*8]);
endmodule : tsb_chk
`default_nettype wire

// file: verification/tb.sv
// Testbench: device and master ends joined by the bus carrier.
// Assumes the package constants; tests use Wishbone and master requests.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tsb_pkg::*;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [3:0]  adr    = 4'h0;
  logic [31:0] wdat   = 32'h0;
  logic [31:0] rdat;
  logic        wack;
  logic        irq;
  logic        rv     = 1'b0;
  logic        rrdy;
  tsb_kind_t   rkind  = TSB_KIND_DATA;
  logic [7:0]  rdata  = 8'h00;
  logic        rack   = 1'b0;
  logic        done;
  logic [7:0]  rx;
  logic        ackd;
  logic        nack;
  int          errors = 0;
  int          checks = 0;
  int          irq_n  = 0;
  int          done_n = 0;
  tsb_if bus ();
  tsb_dev u_tsb_dev (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wack),
    .chan_irq_o(irq), .bus(bus));
  tsb_mst u_tsb_mst (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(rv), .req_ready_o(rrdy),
    .req_kind_i(rkind), .req_data_i(rdata), .req_ack_i(rack), .done_o(done), .rx_data_o(rx),
    .ack_seen_o(ackd), .nack_o(nack), .bus(bus));
  tsb_chk u_tsb_chk (.clk_i(clk_i), .rst_i(rst_i), .sck(bus.sck), .dev_sda_o(bus.dev_sda_o),
    .dev_sda_oe(bus.dev_sda_oe), .mst_sda_o(bus.mst_sda_o), .mst_sda_oe(bus.mst_sda_oe), .sda(bus.sda));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (done === 1'b1) done_n <= done_n + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic tmo;
    errors++;
    $display("[ERR] %0t wait timed out", $time);
    report_and_stop();
  endtask : tmo
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wack !== 1'b1 && n < 16);
    if (wack !== 1'b1) tmo();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd
  task automatic mreq(input tsb_kind_t k, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    rkind <= k;
    rdata <= d;
    rack <= a;
    rv <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rrdy !== 1'b1 && n < 16);
    rv <= 1'b0;
    if (rrdy !== 1'b1) tmo();
  endtask : mreq
  task automatic waitc(ref int c, input int c0);
    for (int i = 0; i < 3000 && c == c0; i++) begin
      @(posedge clk_i);
    end
    if (c == c0) tmo();
  endtask : waitc
  initial begin
    int i0;
    int d0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_CTRL, 32'hffffffff, 32'h0);
    rd(ADR_SADDR, 32'hffffffff, {24'h0, SADDR_RESET});
    rd(4'h2, 32'hffffffff, 32'h0);
    rd(ADR_STAT, 32'h1e1, 32'h0);
    $display("T1 reset done");
    wr(ADR_SHIFT, 32'h5a);
    wr(ADR_CTRL, 32'h1);
    i0 = irq_n;
    d0 = done_n;
    mreq(TSB_KIND_DATA, 8'h3c, 1'b0);
    waitc(done_n, d0);
    chk({31'h0, nack}, 32'h1);
    rd(ADR_STAT, 32'h1, 32'h0);
    chk(32'(irq_n), 32'(i0));
    $display("T2 late enable done");
    wr(ADR_SADDR, 32'ha5);
    wr(ADR_CTRL, 32'h7);
    wr(ADR_SHIFT, 32'hff);
    d0 = done_n;
    mreq(TSB_KIND_ADDR, 8'ha5, 1'b0);
    waitc(irq_n, i0);
    // Busy enable is off, so no busy is held; drop wake-up once the address interrupt is in.
    wr(ADR_CTRL, 32'h5);
    waitc(done_n, d0);
    chk({31'h0, ackd}, 32'h1);
    rd(ADR_STAT, 32'h1e1, 32'h1a1);
    chk(32'(irq_n), 32'(i0 + 1));
    $display("T3 address match done");
    wr(ADR_STAT, 32'h1);
    wr(ADR_CTRL, 32'h1);
    wr(ADR_SHIFT, 32'hc3);
    d0 = done_n;
    mreq(TSB_KIND_DATA, 8'hff, 1'b1);
    waitc(done_n, d0);
    chk({24'h0, rx}, 32'hc3);
    rd(ADR_STAT, 32'h9, 32'h9);
    $display("T4 transmit done");
    wr(ADR_STAT, 32'h1);
    wr(ADR_CTRL, 32'hd);
    wr(ADR_SHIFT, 32'hff);
    d0 = done_n;
    mreq(TSB_KIND_CMD, 8'h77, 1'b0);
    repeat (300) @(posedge clk_i);
    chk(32'(done_n), 32'(d0));
    rd(ADR_STAT, 32'h2e1, 32'h261);
    // Busy enable off but wake-up on must keep the line busy.
    wr(ADR_CTRL, 32'h7);
    repeat (100) @(posedge clk_i);
    chk(32'(done_n), 32'(d0));
    wr(ADR_CTRL, 32'h5);
    waitc(done_n, d0);
    chk({31'h0, ackd}, 32'h1);
    $display("T5 busy done");
    wr(ADR_STAT, 32'h1);
    wr(ADR_CTRL, 32'h3);
    wr(ADR_SHIFT, 32'hff);
    i0 = irq_n;
    d0 = done_n;
    mreq(TSB_KIND_ADDR, 8'h5a, 1'b0);
    // Release lands about seven clocks after the request is taken and the
    // command four clocks later, so the flags are read between the two.
    repeat (8) @(posedge clk_i);
    rd(ADR_STAT, 32'h6, 32'h2);
    repeat (4) @(posedge clk_i);
    rd(ADR_STAT, 32'h6, 32'h6);
    waitc(done_n, d0);
    chk({31'h0, nack}, 32'h1);
    rd(ADR_STAT, 32'h1e0, 32'h80);
    wr(ADR_STAT, 32'h1);
    wr(ADR_SHIFT, 32'hff);
    d0 = done_n;
    mreq(TSB_KIND_DATA, 8'h33, 1'b0);
    waitc(done_n, d0);
    rd(ADR_STAT, 32'h0fe, 32'h010);
    chk(32'(irq_n), 32'(i0));
    $display("T6 wrong address done");
    wr(ADR_STAT, 32'h1);
    wr(ADR_CTRL, 32'h1);
    wr(ADR_SHIFT, 32'hff);
    i0 = irq_n;
    d0 = done_n;
    mreq(TSB_KIND_DATA, 8'h96, 1'b0);
    waitc(irq_n, i0);
    // Automatic acknowledge is off, so only the trigger bit answers.
    wr(ADR_CTRL, 32'h11);
    waitc(done_n, d0);
    chk({31'h0, ackd}, 32'h1);
    rd(ADR_CTRL, 32'h1f, 32'h1);
    rd(ADR_SHIFT, 32'hff, 32'h96);
    $display("T7 ack trigger done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
